// *** hdl/mshc_top.sv ***
// sequencer and held-code store of the 32-channel sample-and-hold
//
// Behaviour
// - addressed channel acquires when hold-release high
// - busy low for whole acquisition
// - single acquisition ends within 16 us
// - busy high, buffer back to converter
// - analog input drives buffer while acquiring
// - held code kept until readdressed
// - power-on zeroes all 33 held codes
// - offset channel acquired, drives offset output
// - 90 to 200 ns low pulse resets
// - pulse under 90 ns is ignored
// - low over 200 ns means hold
// - addressed while low waits for rise
// - offset select overrides channel address
// - all-channel acquire loads all 32, longer
`timescale 1ns/1ps
module mshc_top #(
	parameter int ACQ_CYCLES     = mshc_pkg::ACQ_MAX_CYC,
	parameter int ACQ_ALL_CYCLES = mshc_pkg::ACQ_ALL_CYC
) (
	input  wire logic                 mclk_in,
	input  wire logic                 rst_b_in,
	input  wire logic                 clk_en_in,
	input  wire logic                 addr_load_in,
	input  wire mshc_pkg::mshc_addr_t channel_address_in,
	input  wire logic                 offset_sel_in,
	input  wire logic                 all_channel_in,
	input  wire logic                 hold_release_in,
	input  wire mshc_pkg::mshc_code_t converter_code_in,
	output logic                      busy_b_out,
	output mshc_pkg::mshc_mask_t      route_vin_out,
	output mshc_pkg::mshc_code_t      offset_channel_output_out,
	output logic [mshc_pkg::NUM_REGS*mshc_pkg::CODE_W-1:0] held_code_out
);
	import mshc_pkg::*;

	mshc_state_t      st_reg;
	mshc_state_t      st_next;
	logic [IDX_W-1:0] tgt_reg;
	logic             all_reg;
	mshc_cnt_t        acq_cnt_reg;
	mshc_code_t       held_reg [0:NUM_REGS-1];
	mshc_mask_t       tgt_mask;
	logic [IDX_W-1:0] tgt_next;
	logic             all_next;
	mshc_mask_t       mask_next;
	logic             soft_rst;
	logic             track_low;
	logic             acq_done;
	logic             start_now;

	// ----------------------------------------------------------------
	// pin classifier
	// ----------------------------------------------------------------
	mshc_pulse_class u_class (
		.mclk_in         (mclk_in),
		.rst_b_in        (rst_b_in),
		.clk_en_in       (clk_en_in),
		.pin_in          (hold_release_in),
		.reset_pulse_out (soft_rst),
		.track_low_out   (track_low)
	);

	// ----------------------------------------------------------------
	// target selection
	// ----------------------------------------------------------------
	// offset select wins
	always_comb begin
		tgt_next = tgt_reg;
		all_next = all_reg;
		if (addr_load_in && st_reg == ST_IDLE) begin
			tgt_next = offset_sel_in ? IDX_OFFSET : {1'b0, channel_address_in};
			all_next = all_channel_in;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tgt_reg <= IDX_OFFSET;
			all_reg <= 1'b0;
		end else if (clk_en_in) begin
			if (soft_rst) begin
				tgt_reg <= IDX_OFFSET;
				all_reg <= 1'b0;
			end else begin
				tgt_reg <= tgt_next;
				all_reg <= all_next;
			end
		end
	end

	always_comb begin
		tgt_mask = '0;
		if (all_reg)
			tgt_mask[NUM_CH-1:0] = '1;
		else
			tgt_mask[tgt_reg] = 1'b1;
	end

	// mask of the target being loaded, so routing starts on the load edge
	always_comb begin
		mask_next = '0;
		if (all_next)
			mask_next[NUM_CH-1:0] = '1;
		else
			mask_next[tgt_next] = 1'b1;
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	assign acq_done  = all_reg ? (acq_cnt_reg == CNT_W'(ACQ_ALL_CYCLES - 1))
	                           : (acq_cnt_reg == CNT_W'(ACQ_CYCLES - 1));
	assign start_now = hold_release_in;

	always_comb begin
		st_next = st_reg;
		case (st_reg)
			ST_IDLE: begin
				if (addr_load_in)
					st_next = start_now ? ST_ACQ : ST_WAIT;
			end
			ST_WAIT: begin
				if (start_now)
					st_next = ST_ACQ;
			end
			ST_ACQ: begin
				if (acq_done)
					st_next = ST_IDLE;
			end
			default: st_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			st_reg <= ST_IDLE;
		else if (clk_en_in)
			st_reg <= soft_rst ? ST_IDLE : st_next;
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			acq_cnt_reg <= CNT_ZERO;
		else if (clk_en_in) begin
			if (soft_rst || st_reg != ST_ACQ)
				acq_cnt_reg <= CNT_ZERO;
			else
				acq_cnt_reg <= acq_cnt_reg + CNT_ONE;
		end
	end

	// ----------------------------------------------------------------
	// busy and buffer source
	// ----------------------------------------------------------------
	// busy tracks acquisition
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			busy_b_out <= 1'b1;
		else if (clk_en_in)
			busy_b_out <= soft_rst || st_next != ST_ACQ;
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			route_vin_out <= '0;
		else if (clk_en_in) begin
			if (soft_rst)
				route_vin_out <= '0;
			else if (st_reg == ST_ACQ && acq_done)
				route_vin_out <= '0;
			else if (st_next != ST_IDLE || track_low)
				route_vin_out <= mask_next;
			else
				route_vin_out <= '0;
		end
	end

	// ----------------------------------------------------------------
	// held-code store
	// ----------------------------------------------------------------
	// zero all 33
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (int i = 0; i < NUM_REGS; i++)
				held_reg[i] <= CODE_ZERO;
		end else if (clk_en_in) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				if (soft_rst)
					held_reg[i] <= CODE_ZERO;
				else if (st_reg == ST_ACQ && acq_done && tgt_mask[i])
					held_reg[i] <= converter_code_in;
			end
		end
	end

	assign offset_channel_output_out = held_reg[OFFSET_IDX];

	generate
		for (genvar g = 0; g < NUM_REGS; g++) begin : g_flat
			assign held_code_out[g*CODE_W +: CODE_W] = held_reg[g];
		end
	endgenerate

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in || !clk_en_in);

	property p_start;
		st_reg == ST_IDLE && addr_load_in && hold_release_in && !soft_rst |=> st_reg == ST_ACQ;
	endproperty
	a_start: assert property (p_start) else $error("acquisition did not start");

	property p_busy;
		busy_b_out == (st_reg != ST_ACQ);
	endproperty
	a_busy: assert property (p_busy) else $error("busy does not match acquisition");

	property p_bound;
		$rose(st_reg == ST_ACQ) && !all_reg |-> ##[1:640] st_reg != ST_ACQ;
	endproperty
	a_bound: assert property (p_bound) else $error("acquisition too long");

	property p_release;
		st_reg == ST_ACQ && acq_done && !soft_rst && !track_low |=> busy_b_out && route_vin_out == '0;
	endproperty
	a_release: assert property (p_release) else $error("buffer not released at end");

	property p_route;
		st_reg == ST_ACQ |-> route_vin_out == tgt_mask;
	endproperty
	a_route: assert property (p_route) else $error("input not routed while acquiring");

	property p_hold;
		!(st_reg == ST_ACQ && acq_done) && !soft_rst |=> $stable(held_code_out);
	endproperty
	a_hold: assert property (p_hold) else $error("held code changed");

	property p_soft;
		soft_rst |=> held_code_out == '0 && st_reg == ST_IDLE && busy_b_out;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset incomplete");

	property p_wait;
		st_reg == ST_WAIT && !hold_release_in |=> st_reg != ST_ACQ;
	endproperty
	a_wait: assert property (p_wait) else $error("acquired while held low");

	property p_offsel;
		st_reg == ST_IDLE && addr_load_in && offset_sel_in && !soft_rst |=> tgt_reg == IDX_OFFSET;
	endproperty
	a_offsel: assert property (p_offsel) else $error("offset select ignored");
endmodule

// *** hdl/mshc_pkg.sv ***
// constants and types shared by the sample-and-hold control
package mshc_pkg;
	// ----------------------------------------------------------------
	// channel layout
	// ----------------------------------------------------------------
	localparam int NUM_CH     = 32;
	localparam int NUM_REGS   = 33;
	localparam int OFFSET_IDX = 32;
	localparam int ADDR_W     = 5;
	localparam int CODE_W     = 14;
	localparam int IDX_W      = 6;
	localparam int CNT_W      = 12;
	localparam int LOW_W      = 4;

	typedef logic [CODE_W-1:0]   mshc_code_t;
	typedef logic [ADDR_W-1:0]   mshc_addr_t;
	typedef logic [NUM_REGS-1:0] mshc_mask_t;
	typedef logic [CNT_W-1:0]    mshc_cnt_t;
	typedef logic [LOW_W-1:0]    mshc_low_t;

	localparam mshc_code_t CODE_ZERO  = 14'h0000;
	localparam mshc_cnt_t  CNT_ZERO   = 12'h000;
	localparam mshc_cnt_t  CNT_ONE    = 12'h001;
	localparam mshc_low_t  LOW_ZERO   = 4'h0;
	localparam mshc_low_t  LOW_ONE    = 4'h1;
	localparam logic [IDX_W-1:0] IDX_OFFSET = 6'h20;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int ACQ_MAX_US    = 16;
	localparam int ACQ_ALL_US    = 45;
	localparam int GLITCH_NS     = 90;
	localparam int RESET_MAX_NS  = 200;
	localparam int ACQ_MAX_CYC   = (ACQ_MAX_US * 1000) / CLK_PERIOD_NS;
	localparam int ACQ_ALL_CYC   = (ACQ_ALL_US * 1000) / CLK_PERIOD_NS;
	localparam int GLITCH_CYC    = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_MAX_CYC = RESET_MAX_NS / CLK_PERIOD_NS;

	localparam mshc_low_t GLITCH_LOW = LOW_W'(GLITCH_CYC);
	localparam mshc_low_t RESET_LOW  = LOW_W'(RESET_MAX_CYC);

	// ----------------------------------------------------------------
	// sequencer states, gray along idle-wait-acquire
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_WAIT = 2'h1,
		ST_ACQ  = 2'h3
	} mshc_state_t;
endpackage

// *** hdl/mshc_pulse_class.sv ***
// low-pulse width classifier for the hold-release/reset pin
`timescale 1ns/1ps
module mshc_pulse_class (
	input  wire logic              mclk_in,
	input  wire logic              rst_b_in,
	input  wire logic              clk_en_in,
	input  wire logic              pin_in,
	output logic                   reset_pulse_out,
	output logic                   track_low_out
);
	import mshc_pkg::*;

	logic      pin_prev_reg;
	mshc_low_t low_cnt_reg;

	// ----------------------------------------------------------------
	// low-time counter
	// ----------------------------------------------------------------
	// count low cycles
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			low_cnt_reg  <= LOW_ZERO;
			pin_prev_reg <= 1'b1;
		end else if (clk_en_in) begin
			pin_prev_reg <= pin_in;
			if (pin_in)
				low_cnt_reg <= LOW_ZERO;
			else if (low_cnt_reg <= RESET_LOW)
				low_cnt_reg <= low_cnt_reg + LOW_ONE;
		end
	end

	// ----------------------------------------------------------------
	// classification: reset pulse on the rising edge, long low while the pin is still low
	// ----------------------------------------------------------------
	// width window resets
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			reset_pulse_out <= 1'b0;
		else if (clk_en_in)
			reset_pulse_out <= pin_in && !pin_prev_reg &&
				(low_cnt_reg >= GLITCH_LOW) && (low_cnt_reg <= RESET_LOW);
	end

	assign track_low_out = (low_cnt_reg > RESET_LOW);
endmodule

// *** verification/mshc_host_model.sv ***
// host model driving channel loads and the hold-release/reset pin
`timescale 1ns/1ps
module mshc_host_model (
	input  wire logic            mclk_in,
	output logic                 addr_load_out,
	output mshc_pkg::mshc_addr_t channel_address_out,
	output logic                 offset_sel_out,
	output logic                 all_channel_out,
	output logic                 hold_release_out
);
	import mshc_pkg::*;
	// --------------------------------------------------------
	// idle levels
	// --------------------------------------------------------
	initial begin
		addr_load_out = 1'b0;
		channel_address_out = 5'h00;
		offset_sel_out = 1'b0;
		all_channel_out = 1'b0;
		hold_release_out = 1'b1;
	end
	// --------------------------------------------------------
	// host requests
	// --------------------------------------------------------
	// one-cycle address load, address lines scrambled after
	task automatic load(input mshc_addr_t a, input logic off, input logic all);
		@(negedge mclk_in);
		addr_load_out = 1'b1;
		channel_address_out = a;
		offset_sel_out = off;
		all_channel_out = all;
		@(negedge mclk_in);
		addr_load_out = 1'b0;
		channel_address_out = ~a;
		offset_sel_out = 1'b0;
		all_channel_out = 1'b0;
	endtask
	task automatic set_pin(input logic v);
		@(negedge mclk_in);
		hold_release_out = v;
	endtask
	task automatic pin_low(input int n);
		@(negedge mclk_in);
		hold_release_out = 1'b0;
		repeat (n) @(negedge mclk_in);
		hold_release_out = 1'b1;
	endtask
endmodule

// *** verification/mshc_top_tb.sv ***
// self-checking bench for the sample-and-hold control
`timescale 1ns/1ps
module mshc_top_tb;
	import mshc_pkg::*;
	// --------------------------------------------------------
	// signals
	// --------------------------------------------------------
	localparam int ACQ = 20;
	localparam int ALL = 40;
	typedef struct {mshc_addr_t a; logic off; logic all; mshc_code_t code;} mshc_row_t;
	logic                       mclk_in, rst_b_in, clk_en, addr_load, offset_sel, all_channel, hold_release, busy_b;
	mshc_addr_t                 channel_address;
	mshc_code_t                 converter_code, offset_out;
	mshc_mask_t                 route;
	logic [NUM_REGS*CODE_W-1:0] held;
	mshc_code_t                 exp_code [NUM_REGS];
	int                         fails = 0;
	int                         checked = 0;
	mshc_row_t rows [5] = '{'{5'h00, 1'b0, 1'b0, 14'h1234}, '{5'h1f, 1'b0, 1'b0, 14'h3fff},
		'{5'h05, 1'b1, 1'b0, 14'h0abc}, '{5'h00, 1'b0, 1'b1, 14'h2222}, '{5'h07, 1'b0, 1'b0, 14'h0001}};

	mshc_top #(.ACQ_CYCLES(ACQ), .ACQ_ALL_CYCLES(ALL)) u_mshc_top (
		.mclk_in(mclk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en), .addr_load_in(addr_load),
		.channel_address_in(channel_address), .offset_sel_in(offset_sel), .all_channel_in(all_channel),
		.hold_release_in(hold_release), .converter_code_in(converter_code), .busy_b_out(busy_b),
		.route_vin_out(route), .offset_channel_output_out(offset_out), .held_code_out(held));
	mshc_host_model u_mshc_host_model (
		.mclk_in(mclk_in), .addr_load_out(addr_load), .channel_address_out(channel_address),
		.offset_sel_out(offset_sel), .all_channel_out(all_channel), .hold_release_out(hold_release));

	initial begin
		mclk_in = 1'b0;
		forever #12.5 mclk_in = ~mclk_in;
	end
	// --------------------------------------------------------
	// compare and helper tasks
	// --------------------------------------------------------
	task automatic cmp_vec(input string what, input logic [32:0] e, input logic [32:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic cmp_cnt(input string what, input int e, input int g);
		checked++;
		if (g != e) begin
			fails++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, e, g);
		end
	endtask
	task automatic cmp_codes();
		for (int i = 0; i < NUM_REGS; i++) begin
			cmp_vec("held code", {19'h0, exp_code[i]}, {19'h0, held[i*CODE_W +: CODE_W]});
		end
		cmp_vec("offset output", {19'h0, exp_code[OFFSET_IDX]}, {19'h0, offset_out});
	endtask
	function automatic mshc_mask_t mask_of(input logic off, input logic all, input mshc_addr_t a);
		if (all) return 33'h0ffffffff;
		if (off) return 33'h100000000;
		return 33'h000000001 << a;
	endfunction
	task automatic run_acq(input mshc_mask_t m, input int n);
		int k;
		k = 0;
		cmp_vec("busy", 33'h0, {32'h0, busy_b});
		cmp_vec("route", m, route);
		while (busy_b !== 1'b1 && k < 2000) begin
			@(negedge mclk_in);
			k++;
		end
		cmp_cnt("busy low cycles", n, k);
		cmp_vec("route after", 33'h0, route);
		for (int i = 0; i < NUM_REGS; i++) begin
			if (m[i]) exp_code[i] = converter_code;
		end
		cmp_codes();
	endtask
	task automatic wrap_up();
		$display("checks %0d failures %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// --------------------------------------------------------
	// tests
	// --------------------------------------------------------
	initial begin
		rst_b_in = 1'b0;
		clk_en = 1'b1;
		converter_code = 14'h0000;
		foreach (exp_code[i]) exp_code[i] = 14'h0000;
		repeat (4) @(negedge mclk_in);
		rst_b_in = 1'b1;
		cmp_vec("busy at reset", 33'h1, {32'h0, busy_b});
		cmp_codes();
		$display("test reset done");
		foreach (rows[r]) begin
			converter_code = rows[r].code;
			u_mshc_host_model.load(rows[r].a, rows[r].off, rows[r].all);
			run_acq(mask_of(rows[r].off, rows[r].all, rows[r].a), rows[r].all ? ALL : ACQ);
			$display("test row %0d done", r);
		end
		converter_code = 14'h0555;
		u_mshc_host_model.set_pin(1'b0);
		u_mshc_host_model.load(5'h03, 1'b0, 1'b0);
		repeat (10) @(negedge mclk_in);
		cmp_vec("busy waiting", 33'h1, {32'h0, busy_b});
		cmp_vec("route waiting", 33'h8, route);
		u_mshc_host_model.set_pin(1'b1);
		@(negedge mclk_in);
		run_acq(33'h8, ACQ);
		$display("test wait for rise done");
		u_mshc_host_model.pin_low(2);
		repeat (4) @(negedge mclk_in);
		cmp_codes();
		u_mshc_host_model.pin_low(12);
		repeat (4) @(negedge mclk_in);
		cmp_codes();
		cmp_vec("busy after hold", 33'h1, {32'h0, busy_b});
		$display("test glitch and hold done");
		// clock enable low ignores a load and stalls the busy count
		clk_en = 1'b0;
		converter_code = 14'h0777;
		u_mshc_host_model.load(5'h09, 1'b0, 1'b0);
		cmp_vec("busy frozen", 33'h1, {32'h0, busy_b});
		clk_en = 1'b1;
		u_mshc_host_model.load(5'h09, 1'b0, 1'b0);
		clk_en = 1'b0;
		repeat (10) @(negedge mclk_in);
		clk_en = 1'b1;
		run_acq(33'h200, ACQ);
		$display("test clock enable done");
		u_mshc_host_model.pin_low(6);
		repeat (4) @(negedge mclk_in);
		foreach (exp_code[i]) exp_code[i] = 14'h0000;
		cmp_codes();
		$display("test soft reset done");
		wrap_up();
	end
	initial begin
		repeat (5000) @(posedge mclk_in);
		fails++;
		$display("watchdog expired");
		wrap_up();
	end
endmodule
